// ---- hdl/xfer_pkg.sv ----
`default_nettype none
// ============================================================
// shared constants and carriers of the serial transfer engine
package xfer_pkg;
	// host register offsets on the four address lines
	localparam logic [3:0] OFS_DEV0   = 4'h0;
	localparam logic [3:0] OFS_FIRST  = 4'h8;
	localparam logic [3:0] OFS_SECOND = 4'h9;
	localparam logic [3:0] OFS_STATUS = 4'ha;
	localparam logic [3:0] OFS_CSEL   = 4'hb;
	localparam logic [3:0] OFS_PDIR   = 4'hc;
	localparam logic [3:0] OFS_POL    = 4'hd;
	localparam logic [3:0] OFS_WIDTH  = 4'he;
	localparam logic [3:0] OFS_RATE   = 4'hf;
	// values after reset
	localparam logic [7:0] PDIR_RST   = 8'hff;
	localparam logic [7:0] CSEL_RST   = 8'hff;
	localparam logic [7:0] POL_RST    = 8'h00;
	localparam logic [7:0] WIDTH_RST  = 8'h00;
	localparam logic [7:0] RATE_RST   = 8'h00;
	// field positions in the rate/control and status registers; generic device number
	localparam int INTEN_BIT = 7;
	localparam int SOI_BIT   = 6;
	localparam int MS_BIT    = 5;
	localparam int DIV_LSB   = 0;
	localparam int DONE_BIT  = 7;
	localparam logic [2:0] GENERIC_DEV = 3'h7;
	// cycle counts
	localparam logic [4:0] LAST_TOG16  = 5'h1f;
	localparam logic [4:0] LAST_TOG8   = 5'h0f;
	localparam logic [4:0] LAST_SAMP16 = 5'h0f;
	localparam logic [4:0] LAST_SAMP8  = 5'h07;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	// one captured host write
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} host_wr_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD, ST_SLAVE
	} xfer_state_t;
endpackage
`default_nettype wire

// ---- hdl/bit_sync.sv ----
`default_nettype none
// ============================================================
// two-flop synchroniser for pins; resets high so idle strobes
// do not look like a write at release
module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	if (W < 1) begin : g_chk
		$error("bit_sync needs at least one bit");
	end

	// first stage is read by the second stage only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '1;
			q_r    <= '1;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end
	assign q = q_r;
endmodule
`default_nettype wire

// ---- hdl/two_entry_buf.sv ----
`default_nettype none
// ============================================================
// two-entry buffer; in_ready drops when both entries hold data
module two_entry_buf #(
	parameter int W     = 12,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_r   [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic         wp_r, wp_nxt;
	logic         rp_r, rp_nxt;
	logic [1:0]   cnt_r, cnt_nxt;
	logic         push, pull;

	if (DEPTH != 2) begin : g_chk
		$error("two_entry_buf holds exactly two words");
	end

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];

	// pointer and storage update
	always_comb begin
		push    = in_valid & in_ready;
		pull    = out_valid & out_ready;
		mem_nxt = mem_r;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt        = ~wp_r;
		end
		if (pull)
			rp_nxt = ~rp_r;
		if (push && !pull)
			cnt_nxt = cnt_r + 2'h1;
		else if (pull && !push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			mem_r <= mem_nxt;
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/transfer_engine.sv ----
`default_nettype none
// ============================================================
// Overview of operation
// RULE1: low byte second register, high byte starts
// RULE2: hardware pulls select low around transfer
// RULE3: returned bytes land in both data registers
// RULE4: eight device addresses, own settings, own select
// RULE5: master select 0 drives clock, data out
// RULE6: master first byte write: msb out, done clear
// RULE7: master end: done set, data output released
// RULE8: generic registers use device seven settings
// RULE9: master select 1 takes external clock
// RULE10: slave ignores clock edges while done
// RULE11: slave first byte write arms external clock
// RULE12: slave done after 8 or 16 pulses
// RULE13: device addresses unused in slave mode
// RULE14: data output pin may act as input
// RULE15: select pins are inputs after reset
// RULE16: host sets polarity, then width bits
// RULE17: long frames built from several transfers
// RULE18: done drives interrupt when enabled, non-multiplexed
// RULE19: reset leaves master mode, output data pin
// RULE20: software select cleared before data writes
// RULE21: host deselects after done is seen
// RULE22: status bit seven done, reads 80 hex
// RULE23: polarity 0 falling launch, 1 rising launch
// RULE24: software low select overrides hardware release
// RULE25: msb first, received bits replace sent bits
module transfer_engine (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       host_ce_n,
	input  wire logic       host_rd_n,
	input  wire logic       host_wr_n,
	input  wire logic [3:0] host_addr,
	input  wire logic [7:0] host_data_in,
	output logic      [7:0] host_data_out,
	output logic            host_data_oe,
	output logic            host_ready,
	input  wire logic       bus_mux_n,
	input  wire logic [7:0] select_pin_in,
	output logic      [7:0] select_pin_out,
	output logic      [7:0] select_pin_oe,
	output logic            serial_clock_pin,
	input  wire logic       clock_input_pin,
	input  wire logic       sdi,
	input  wire logic       sdo_in,
	output logic            sdo_out,
	output logic            sdo_oe,
	output logic            irq_n
);
	localparam int NS = 27;
	localparam int HW = $bits(xfer_pkg::host_wr_t);

	// ============================================================
	// pin synchronisers
	logic [NS-1:0] raw, syn;
	logic          ce_n_s, rd_n_s, wr_n_s, mux_n_s;
	logic          sck_s, sdi_s, sdo_in_s;
	logic [3:0]    addr_s;
	logic [7:0]    data_s, sel_in_s;

	assign raw = {host_ce_n, host_rd_n, host_wr_n, host_addr,
		host_data_in, bus_mux_n, select_pin_in,
		clock_input_pin, sdi, sdo_in};
	bit_sync #(.W(NS)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (raw),
		.q     (syn)
	);
	assign {ce_n_s, rd_n_s, wr_n_s, addr_s, data_s, mux_n_s,
		sel_in_s, sck_s, sdi_s, sdo_in_s} = syn;

	// address holds a first-byte location (device or generic)
	function automatic logic is_fb(input logic [3:0] a);
		return a <= xfer_pkg::OFS_FIRST;
	endfunction

	// one sample step: 16-bit shifts through both bytes
	function automatic logic [15:0] shift16(input logic [15:0] v,
		input logic w, input logic b);
		return w ? {v[14:0], b} : {v[14:8], b, v[7:0]};
	endfunction

	// ============================================================
	// host side: capture writes on trailing strobe edge
	xfer_pkg::host_wr_t cap_r, cap_nxt, pop_w;
	logic       wr_act_r, wr_act_nxt, push;
	logic       in_ready, pop_valid, pop_ready, pop;
	logic       ready_r, rd_oe_r, rd_oe_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	// reads of device registers, declared below
	xfer_pkg::xfer_state_t st_r, st_nxt;
	logic [7:0] fb_r, fb_nxt, sb_r, sb_nxt;
	logic [7:0] csel_r, csel_nxt, pdir_r, pdir_nxt;
	logic [7:0] pol_r, pol_nxt, wid_r, wid_nxt;
	logic [7:0] rate_r, rate_nxt, sel_r, sel_nxt, soe_r;
	logic       done_r, done_nxt, bit_r, bit_nxt;
	logic       oe_r, oe_nxt, sclk_r, sclk_nxt, hw_r, hw_nxt;
	logic [2:0] dev_r, dev_nxt;
	logic [4:0] tog_r, tog_nxt, last_tog, last_samp;
	logic [7:0] div_r, div_nxt, half;
	logic       sck_prev_r, nonmux_r, nonmux_nxt, irq_r;
	logic [1:0] strap_r, strap_nxt;
	logic       ms, soi, cur_pol, cur_wid, tick, rx;
	logic       samp_ed, launch_ed, hw_busy, start;
	logic [15:0] sh;

	always_comb begin
		wr_act_nxt = ~ce_n_s & ~wr_n_s;
		push       = wr_act_r & ~wr_act_nxt;
		cap_nxt    = wr_act_nxt ? {addr_s, data_s} : cap_r;
		rd_oe_nxt  = ~ce_n_s & ~rd_n_s;
		rdata_nxt  = 8'h00; // write-only locations read zero
		if (is_fb(addr_s))
			rdata_nxt = fb_r; // [RULE3]
		else if (addr_s == xfer_pkg::OFS_SECOND)
			rdata_nxt = sb_r; // [RULE3]
		else if (addr_s == xfer_pkg::OFS_STATUS)
			rdata_nxt = {done_r, 7'h00}; // [RULE22]
		else if (addr_s == xfer_pkg::OFS_CSEL)
			rdata_nxt = (sel_in_s & pdir_r) | ~pdir_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_act_r <= 1'b0;
			cap_r    <= '0;
			ready_r  <= 1'b0;
			rd_oe_r  <= 1'b0;
			rdata_r  <= 8'h00;
		end else begin
			wr_act_r <= wr_act_nxt;
			cap_r    <= cap_nxt;
			ready_r  <= in_ready;
			rd_oe_r  <= rd_oe_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// data writes wait for an idle engine; config at the buffer head never stalls,
	// but stalls behind a waiting data write, so a slave on a silent master locks the host once both entries fill
	two_entry_buf #(.W(HW), .DEPTH(2)) u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   (cap_r),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_w)
	);
	assign pop_ready = (st_r == xfer_pkg::ST_IDLE)
		| ~(is_fb(pop_w.addr) | (pop_w.addr == xfer_pkg::OFS_SECOND));
	assign pop = pop_valid & pop_ready;

	// ============================================================
	// transfer engine and configuration
	always_comb begin
		ms       = rate_r[xfer_pkg::MS_BIT];
		soi      = rate_r[xfer_pkg::SOI_BIT];
		cur_pol  = pol_r[dev_r]; // [RULE4]
		cur_wid  = wid_r[dev_r];
		half     = 8'h01 << rate_r[xfer_pkg::DIV_LSB +: 3];
		tick     = (div_r == 8'(half - 8'h01));
		last_tog = cur_wid ? xfer_pkg::LAST_TOG16
			: xfer_pkg::LAST_TOG8;
		last_samp = cur_wid ? xfer_pkg::LAST_SAMP16
			: xfer_pkg::LAST_SAMP8;
		rx = soi ? sdo_in_s : sdi_s; // [RULE14]
		samp_ed   = cur_pol ? (~sck_s & sck_prev_r)
			: (sck_s & ~sck_prev_r); // [RULE23]
		launch_ed = cur_pol ? (sck_s & ~sck_prev_r)
			: (~sck_s & sck_prev_r);
		sh = shift16({fb_r, sb_r}, cur_wid, rx); // [RULE25]
		st_nxt = st_r;   fb_nxt = fb_r;     sb_nxt = sb_r;
		csel_nxt = csel_r; pdir_nxt = pdir_r; pol_nxt = pol_r;
		wid_nxt = wid_r; rate_nxt = rate_r; done_nxt = done_r;
		bit_nxt = bit_r; oe_nxt = oe_r;     sclk_nxt = sclk_r;
		hw_nxt = hw_r;   dev_nxt = dev_r;   tog_nxt = tog_r;
		div_nxt = 8'h00; start = 1'b0;
		// master runs on half-period ticks, slave on pin edges
		unique case (st_r)
			xfer_pkg::ST_IDLE: ; // pin edges ignored while done [RULE10]
			xfer_pkg::ST_SETUP: begin
				div_nxt = tick ? 8'h00 : div_r + 8'h01;
				if (tick)
					st_nxt = xfer_pkg::ST_SHIFT;
			end
			xfer_pkg::ST_SHIFT: begin
				div_nxt = tick ? 8'h00 : div_r + 8'h01;
				if (tick) begin
					sclk_nxt = ~sclk_r; // [RULE5]
					tog_nxt  = tog_r + 5'h01;
					if (!tog_r[0])
						{fb_nxt, sb_nxt} = sh; // [RULE25]
					else if (tog_r != last_tog)
						bit_nxt = fb_r[7];
					if (tog_r == last_tog)
						st_nxt = xfer_pkg::ST_HOLD; // [RULE1]
				end
			end
			xfer_pkg::ST_HOLD: begin
				div_nxt = tick ? 8'h00 : div_r + 8'h01;
				if (tick) begin
					st_nxt   = xfer_pkg::ST_IDLE;
					done_nxt = 1'b1; // [RULE7]
					oe_nxt   = 1'b0; // [RULE7]
				end
			end
			xfer_pkg::ST_SLAVE: begin
				if (samp_ed) begin
					{fb_nxt, sb_nxt} = sh; // [RULE11]
					tog_nxt = tog_r + 5'h01;
					if (tog_r == last_samp) begin
						st_nxt   = xfer_pkg::ST_IDLE;
						done_nxt = 1'b1; // [RULE12]
						oe_nxt   = 1'b0; // [RULE12]
					end
				end else if (launch_ed) begin
					bit_nxt = fb_r[7];
				end
			end
		endcase
		// host writes leaving the buffer
		if (pop) begin
			if (is_fb(pop_w.addr)) begin
				// device locations ignored as a whole in slave mode
				if (pop_w.addr == xfer_pkg::OFS_FIRST || !ms) begin
					start    = 1'b1; // [RULE13]
					fb_nxt   = pop_w.data;
					bit_nxt  = pop_w.data[7]; // [RULE6] [RULE11]
					done_nxt = 1'b0; // [RULE6] [RULE11]
					oe_nxt   = ~soi; // [RULE14]
					hw_nxt   = (pop_w.addr != xfer_pkg::OFS_FIRST);
					dev_nxt  = hw_nxt ? pop_w.addr[2:0]
						: xfer_pkg::GENERIC_DEV; // [RULE8] [RULE4]
					tog_nxt  = 5'h00;
					sclk_nxt = pol_r[dev_nxt];
					st_nxt   = ms ? xfer_pkg::ST_SLAVE
						: xfer_pkg::ST_SETUP; // [RULE5] [RULE9]
				end
			end else begin
				unique case (pop_w.addr)
					xfer_pkg::OFS_SECOND: sb_nxt   = pop_w.data;
					xfer_pkg::OFS_CSEL:   csel_nxt = pop_w.data;
					xfer_pkg::OFS_PDIR:   pdir_nxt = pop_w.data;
					xfer_pkg::OFS_POL:    pol_nxt  = pop_w.data;
					xfer_pkg::OFS_WIDTH:  wid_nxt  = pop_w.data;
					xfer_pkg::OFS_RATE:   rate_nxt = pop_w.data;
					default: ; // status is read-only
				endcase
			end
		end
		// hardware only pulls low; a software 0 stays low
		hw_busy = hw_r & (st_r inside {xfer_pkg::ST_SETUP,
			xfer_pkg::ST_SHIFT, xfer_pkg::ST_HOLD});
		sel_nxt = csel_r & ~(hw_busy ? (8'h01 << dev_r)
			: 8'h00); // [RULE2] [RULE24]
		// the strap is taken once the synchroniser has settled
		strap_nxt  = (strap_r == xfer_pkg::STRAP_SETTLE)
			? strap_r : strap_r + 2'h1;
		nonmux_nxt = (strap_r == xfer_pkg::STRAP_SETTLE)
			? nonmux_r : mux_n_s;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r   <= xfer_pkg::ST_IDLE;
			fb_r   <= 8'h00;
			sb_r   <= 8'h00;
			csel_r <= xfer_pkg::CSEL_RST;
			pdir_r <= xfer_pkg::PDIR_RST; // [RULE15]
			pol_r  <= xfer_pkg::POL_RST;
			wid_r  <= xfer_pkg::WIDTH_RST;
			rate_r <= xfer_pkg::RATE_RST; // [RULE19]
			sel_r  <= 8'hff;
			soe_r  <= 8'h00;
			done_r <= 1'b1; // [RULE22]
			bit_r  <= 1'b0;
			oe_r   <= 1'b0;
			sclk_r <= 1'b0;
			hw_r   <= 1'b0;
			dev_r  <= xfer_pkg::GENERIC_DEV;
			tog_r  <= 5'h00;
			div_r  <= 8'h00;
			sck_prev_r <= 1'b1;
			strap_r    <= 2'h0;
			nonmux_r   <= 1'b1;
			irq_r      <= 1'b1;
		end else begin
			st_r   <= st_nxt;
			fb_r   <= fb_nxt;
			sb_r   <= sb_nxt;
			csel_r <= csel_nxt;
			pdir_r <= pdir_nxt;
			pol_r  <= pol_nxt;
			wid_r  <= wid_nxt;
			rate_r <= rate_nxt;
			sel_r  <= sel_nxt;
			soe_r  <= ~pdir_r; // [RULE15]
			done_r <= done_nxt;
			bit_r  <= bit_nxt;
			oe_r   <= oe_nxt;
			sclk_r <= sclk_nxt;
			hw_r   <= hw_nxt;
			dev_r  <= dev_nxt;
			tog_r  <= tog_nxt;
			div_r  <= div_nxt;
			sck_prev_r <= sck_s;
			strap_r    <= strap_nxt;
			nonmux_r   <= nonmux_nxt;
			irq_r <= ~(rate_r[xfer_pkg::INTEN_BIT] & done_r
				& nonmux_r); // [RULE18]
		end
	end

	assign host_data_out    = rdata_r;
	assign host_data_oe     = rd_oe_r;
	assign host_ready       = ready_r;
	assign select_pin_out   = sel_r;
	assign select_pin_oe    = soe_r;
	assign serial_clock_pin = sclk_r;
	assign sdo_out          = bit_r;
	assign sdo_oe           = oe_r;
	assign irq_n            = irq_r;

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_last_tick;
		st_r == xfer_pkg::ST_HOLD && tick;
	endsequence

	start_clears_done_a: assert property ( // [RULE6]
		start |=> !done_r && sdo_out == $past(pop_w.data[7]))
		else $error("start did not clear done or load msb");
	master_end_a: assert property ( // [RULE7]
		s_last_tick |=> done_r && !sdo_oe)
		else $error("master end did not set done and release");
	length_a: assert property ( // [RULE1]
		st_r == xfer_pkg::ST_SHIFT && tick && tog_r == last_tog
		|=> st_r == xfer_pkg::ST_HOLD && sclk_r == cur_pol)
		else $error("shift length or idle clock level wrong");
	select_low_a: assert property ( // [RULE2]
		st_r == xfer_pkg::ST_SHIFT && hw_r |-> !sel_r[dev_r])
		else $error("select not low during hardware transfer");
	select_release_a: assert property ( // [RULE2]
		$fell(hw_busy) && csel_r[dev_r] |=> sel_r[dev_r])
		else $error("select not released after transfer");
	generic_dev7_a: assert property ( // [RULE8]
		start && pop_w.addr == xfer_pkg::OFS_FIRST
		|=> dev_r == xfer_pkg::GENERIC_DEV && !hw_r)
		else $error("generic transfer not using device seven");
	slave_ignore_a: assert property ( // [RULE10]
		ms && done_r && !start |=> $stable(bit_r) && done_r)
		else $error("slave moved while done");
	slave_count_a: assert property ( // [RULE12]
		st_r == xfer_pkg::ST_SLAVE && samp_ed && tog_r == last_samp
		|=> done_r && !sdo_oe ##1 done_r)
		else $error("slave did not finish after last pulse");
	slave_no_dev_a: assert property ( // [RULE13]
		pop && ms && is_fb(pop_w.addr)
		&& pop_w.addr != xfer_pkg::OFS_FIRST
		|=> st_r == xfer_pkg::ST_IDLE && $stable(fb_r))
		else $error("device address started a slave transfer");
	irq_follow_a: assert property ( // [RULE18]
		rate_r[xfer_pkg::INTEN_BIT] && done_r && nonmux_r
		|=> !irq_n)
		else $error("interrupt not raised on done");
endmodule
`default_nettype wire

// ---- tb/periph_model.sv ----
`default_nettype none
// ============================================================
// serial peripheral on separate data-in and data-out lines
module periph_model (
	input  wire logic        sclk,
	input  wire logic        sel_n,
	input  wire logic        sdo,
	input  wire logic [15:0] reply,
	output logic             sdi,
	output logic      [15:0] got
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh;

	// idle values before the first frame
	initial begin
		sdi = 1'b0;
		got = 16'h0000;
		sh  = 16'h0000;
	end

	// selection loads the answer; msb goes out first
	always @(negedge sel_n) begin
		sh  = reply;
		sdi = reply[15];
		got = 16'h0000;
	end

	// normal polarity: sample on rising, launch on falling
	always @(posedge sclk) begin
		if (!sel_n) got = {got[14:0], sdo};
	end
	always @(negedge sclk) begin
		if (!sel_n) begin
			sh  = {sh[14:0], 1'b0};
			sdi = sh[15];
		end
	end

	// released line must not keep its last level
	always @(posedge sel_n) begin
		sdi = ~sdi;
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
// ============================================================
// bench for the serial transfer engine
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, ce_n, rd_n, wr_n, rdy, clk_in, tb_sdi;
	logic        slave_en, sclk, sdo_out, sdo_oe, irq_n, model_sdi;
	logic        oe_q, first_bit, mux_n;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata, sel_pin, sel_out, sel_oe, low_seen;
	logic [15:0] reply, got;
	int          n_mismatch, check_count;
	wire         sdo_line;

	// select pins have pull-ups; a released data-out line is driven
	// by the peripheral, as a three-pin part shares that wire
	assign sel_pin  = (sel_oe & sel_out) | ~sel_oe;
	assign sdo_line = sdo_oe ? sdo_out : model_sdi;

	transfer_engine transfer_engine_i (
		.clk(clk), .rst_n(rst_n), .host_ce_n(ce_n), .host_rd_n(rd_n),
		.host_wr_n(wr_n), .host_addr(addr), .host_data_in(wdata),
		.host_data_out(rdata), .host_data_oe(), .host_ready(rdy),
		.bus_mux_n(mux_n), .select_pin_in(sel_pin),
		.select_pin_out(sel_out), .select_pin_oe(sel_oe),
		.serial_clock_pin(sclk), .clock_input_pin(clk_in),
		.sdi(slave_en ? tb_sdi : model_sdi), .sdo_in(sdo_line),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .irq_n(irq_n));

	periph_model periph_model_i (
		.sclk(sclk), .sel_n(&sel_pin), .sdo(sdo_line),
		.reply(reply), .sdi(model_sdi), .got(got));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// first bit presented and select pins that ever went low
	always @(posedge clk) begin
		oe_q <= sdo_oe;
		if (sdo_oe && !oe_q) first_bit <= sdo_out;
		low_seen <= low_seen | ~sel_pin;
	end

	// ============================================================
	// shared tasks
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// strobes four clocks low, six high so the write has landed on return
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int i;
		for (i = 0; i < 100 && rdy !== 1'b1; i++) @(negedge clk);
		addr  = a;
		wdata = d;
		ce_n  = 1'b0;
		wr_n  = 1'b0;
		repeat (4) @(negedge clk);
		wr_n = 1'b1;
		ce_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		addr = a;
		ce_n = 1'b0;
		rd_n = 1'b0;
		repeat (6) @(negedge clk);
		check("read", 16'(rdata), 16'(exp));
		rd_n = 1'b1;
		ce_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_reset;
		rdchk(xfer_pkg::OFS_STATUS, 8'h80);
		check("select oe", 16'(sel_oe), 16'h0000);
		check("data oe", 16'(sdo_oe), 16'h0000);
		rdchk(xfer_pkg::OFS_CSEL, 8'hff);
	endtask

	// every device address, device three as the 16-bit one
	task automatic t_dev;
		logic [15:0] tx;
		logic        w;
		int          d;
		wr(xfer_pkg::OFS_PDIR, 8'h00);
		wr(xfer_pkg::OFS_POL, 8'h00);
		wr(xfer_pkg::OFS_WIDTH, 8'h08);
		wr(xfer_pkg::OFS_RATE, 8'h83);
		for (d = 0; d < 8; d++) begin
			w     = (d == 3);
			tx    = {8'h1e + 8'(d * 31), 8'ha5 ^ 8'(d)};
			reply = {8'h5a + 8'(d), 8'hc3 - 8'(d)};
			low_seen = 8'h00;
			if (w) wr(xfer_pkg::OFS_SECOND, tx[7:0]);
			wr(4'(d), tx[15:8]);
			rdchk(xfer_pkg::OFS_STATUS, 8'h00);
			check("irq busy", 16'(irq_n), 16'h0001);
			rdchk_done();
			check("msb", 16'(first_bit), 16'(tx[15]));
			check("sent", w ? got : 16'(got[7:0]),
				w ? tx : 16'(tx[15:8]));
			check("sel", 16'(low_seen), 16'(8'h01 << d));
			check("sel end", 16'(sel_pin), 16'h00ff);
			check("oe end", 16'(sdo_oe), 16'h0000);
			check("irq", 16'(irq_n), 16'h0000);
			rdchk(4'(d), reply[15:8]);
			if (w) rdchk(xfer_pkg::OFS_SECOND, reply[7:0]);
		end
	endtask

	task automatic rdchk_done;
		logic [7:0] s;
		int         i;
		s = 8'h00;
		for (i = 0; i < 100 && s[7] !== 1'b1; i++) begin
			addr = xfer_pkg::OFS_STATUS;
			ce_n = 1'b0;
			rd_n = 1'b0;
			repeat (6) @(negedge clk);
			s    = rdata;
			rd_n = 1'b1;
			ce_n = 1'b1;
			repeat (4) @(negedge clk);
		end
		check("done", 16'(s), 16'h0080);
	endtask

	// generic registers under software select, device seven width
	task automatic t_soft(input logic w);
		reply = 16'h9c3e;
		wr(xfer_pkg::OFS_WIDTH, w ? 8'h88 : 8'h08);
		wr(xfer_pkg::OFS_CSEL, 8'hfd);
		if (w) wr(xfer_pkg::OFS_SECOND, 8'h77);
		wr(xfer_pkg::OFS_FIRST, 8'h66);
		rdchk_done();
		check("soft sent", w ? got : 16'(got[7:0]),
			w ? 16'h6677 : 16'h0066);
		check("soft sel", 16'(sel_pin), 16'h00fd);
		rdchk(xfer_pkg::OFS_FIRST, 8'h9c);
		wr(xfer_pkg::OFS_CSEL, 8'hff);
		check("soft off", 16'(sel_pin), 16'h00ff);
	endtask

	// external clock at 320 ns; launch on falling, sample on rising
	task automatic pulses(input int n, input logic [7:0] rx,
			output logic [7:0] cap);
		int i;
		cap = 8'h00;
		for (i = n - 1; i >= 0; i--) begin
			tb_sdi = rx[i];
			repeat (4) @(negedge clk);
			clk_in = 1'b1;
			cap    = {cap[6:0], sdo_out};
			repeat (4) @(negedge clk);
			clk_in = 1'b0;
		end
	endtask

	task automatic t_slave;
		logic [7:0] cap;
		wr(xfer_pkg::OFS_RATE, 8'h20);
		slave_en = 1'b1;
		check("irq off", 16'(irq_n), 16'h0001);
		pulses(2, 8'hff, cap);
		rdchk(xfer_pkg::OFS_STATUS, 8'h80);
		check("slave idle", 16'(sdo_oe), 16'h0000);
		wr(4'h0, 8'h11);
		check("dev in slave", 16'(sdo_oe), 16'h0000);
		wr(xfer_pkg::OFS_FIRST, 8'ha5);
		check("slave oe", 16'(sdo_oe), 16'h0001);
		check("slave msb", 16'(first_bit), 16'h0001);
		pulses(8, 8'h3c, cap);
		repeat (8) @(negedge clk);
		check("slave sent", 16'(cap), 16'h00a5);
		check("slave oe end", 16'(sdo_oe), 16'h0000);
		rdchk(xfer_pkg::OFS_STATUS, 8'h80);
		rdchk(xfer_pkg::OFS_FIRST, 8'h3c);
	endtask

	// shared line: sdi held low, so only the data-out pin can answer
	task automatic t_three;
		reply    = 16'h4b00;
		slave_en = 1'b1;
		tb_sdi   = 1'b0;
		wr(xfer_pkg::OFS_RATE, 8'h43);
		wr(4'h5, 8'h00);
		check("line oe", 16'(sdo_oe), 16'h0000);
		rdchk_done();
		rdchk(4'h5, 8'h4b);
	endtask

	// second reset with the multiplexed strap keeps the interrupt off
	task automatic t_mux;
		rst_n = 1'b0;
		mux_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		rdchk(xfer_pkg::OFS_STATUS, 8'h80);
		wr(xfer_pkg::OFS_RATE, 8'h80);
		check("irq mux", 16'(irq_n), 16'h0001);
	endtask

	// ============================================================
	// main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		{ce_n, rd_n, wr_n} = 3'h7;
		addr = 4'h0;
		wdata = 8'h00;
		{clk_in, tb_sdi, slave_en, oe_q, first_bit} = 5'h00;
		reply = 16'h0000;
		low_seen = 8'h00;
		mux_n = 1'b1;
		n_mismatch = 0;
		check_count = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_dev();
		t_soft(1'b1);
		t_soft(1'b0);
		t_slave();
		t_three();
		t_mux();
		stop_test();
	end

	// generous against the roughly 2500 clocks needed
	initial begin
		#2000000;
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
